// ---- design/iobc_ctrl.sv ----
`timescale 1ns/1ps
module iobc_ctrl import iobc_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Clock outputs
    output logic clk_div4_out,
    output logic clk_inv_out,
    // System bus side
    input wire logic io_cycle_ask_n,
    input wire logic [1:0] cycle_type,
    input wire logic rd_wr_n,
    input wire logic chip_sel,
    input wire logic [2:0] bank_select,
    input wire logic [4:0] word_index,
    output logic io_grant_n_o,
    output logic io_grant_n_oe,
    output logic int_reg_sel,
    output logic [4:0] int_reg_index,
    // Buffer and peripheral control
    output logic data_latch_hold_n_o,
    output logic data_latch_hold_n_oe,
    output logic rd_buffer_en_n,
    output logic wr_buffer_en_n,
    output logic external_select_n,
    output logic [7:1] peripheral_select_n,
    output logic periph_rd_strobe_n,
    output logic periph_wr_strobe_n,
    // Reset pins
    input wire logic power_on_rst_n,
    input wire logic sys_rst_pin_i,
    output logic sys_rst_pin_o,
    output logic sys_rst_pin_oe,
    output logic warm_restart,
    // Interrupt pins
    input wire logic [7:0] level_int_in_n,
    input wire logic falling_int_in_n,
    input wire logic rising_int_in,
    input wire logic [1:0] fast_int_hi_in,
    input wire logic fast_int_lo_in,
    input wire logic [2:0] edge_clear,
    input wire logic [2:0] edge_mask,
    input wire logic [7:0] level_mask,
    input wire logic fast_mask,
    output logic [2:0] edge_status,
    output logic [2:0] edge_request,
    output logic [7:0] level_request,
    output logic fast_int_out_n,
    // Control pins
    input wire logic [5:0] control_prog,
    input wire logic [5:0] control_pins_i,
    output logic [5:0] control_pins_o,
    output logic [5:0] control_pins_oe,
    output logic [5:0] control_pins_rd,
    // Baud and keyboard
    input wire logic [15:0] baud_reload,
    input wire logic [15:0] kbd_reload,
    output logic baud_out,
    input wire logic kbd_serial_in,
    output logic [7:0] kbd_rx_data,
    output logic kbd_rx_ready,
    input wire logic kbd_tx_load,
    input wire logic [7:0] kbd_tx_data,
    output logic kbd_tx_done,
    output logic kbd_serial_out
);
    // ==========================================
    // State
    typedef struct packed {
        logic [1:0] div;
        logic div4;
        iobc_cyc_t cyc;
        logic [3:0] wcnt;
        logic internal;
        logic ext;
        logic rd;
        logic wr;
        logic [2:0] bank;
        logic grant;
        logic [13:0] s1;
        logic [13:0] s2;
        logic [2:0] edge_st;
        logic rise_prev;
        logic fall_prev;
        logic por_seen;
        logic rst_prev;
        logic warm;
        logic baud;
        logic rx_busy;
        logic [3:0] rx_ph;
        logic [3:0] rx_bit;
        logic [7:0] rx_sh;
        logic [7:0] rx_data;
        logic rx_rdy;
        logic tx_busy;
        logic [3:0] tx_ph;
        logic [3:0] tx_bit;
        logic [10:0] tx_sh;
        logic tx_done;
    } iobc_st_t;
    iobc_st_t st_r, st_nxt;

    logic tick4, baud_uf, kbd_uf;
    logic [7:0] lvl_s;
    logic fall_s, rise_s, por_s, rstpin_s, kin_s, flo_s;
    logic [1:0] fhi_s;
    logic [5:0] ctl_s;
    logic [3:0] wait_sel;

    // Second stage of the pin synchronisers
    assign {lvl_s, fall_s, rise_s, por_s, rstpin_s} = st_r.s2[11:0];
    assign kin_s = st_r.s2[12];
    assign flo_s = st_r.s2[13];
    assign tick4 = (st_r.div == 2'h3);

    // ==========================================
    // Timers for baud pin and keyboard rate
    iobc_reload_cnt u_baud_cnt (
        .clk(clk),
        .sys_rst(sys_rst),
        .tick(tick4),
        .reload(baud_reload),
        .underflow(baud_uf)
    );
    iobc_reload_cnt u_kbd_cnt (
        .clk(clk),
        .sys_rst(sys_rst),
        .tick(1'b1),
        .reload(kbd_reload),
        .underflow(kbd_uf)
    );

    // fast_int_hi_in and control pins are two-stage synchronised separately
    logic [1:0] fhi_m, fhi_q;
    logic [5:0] ctl_m, ctl_q;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            fhi_m <= 2'h0;
            fhi_q <= 2'h0;
            ctl_m <= 6'h3F;
            ctl_q <= 6'h3F;
        end else begin
            fhi_m <= fast_int_hi_in;
            fhi_q <= fhi_m;
            ctl_m <= control_pins_i;
            ctl_q <= ctl_m;
        end
    end
    assign fhi_s = fhi_q;
    assign ctl_s = ctl_q;

    always_comb begin
        unique case (cycle_type)
            TYPE_SLOW: wait_sel = WAIT_SLOW;
            TYPE_MED: wait_sel = WAIT_MED;
            TYPE_FAST: wait_sel = WAIT_FAST;
            TYPE_SYNC: wait_sel = WAIT_SYNC;
        endcase
    end

    // ==========================================
    // Next state
    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = {fast_int_lo_in, kbd_serial_in, level_int_in_n, falling_int_in_n,
                     rising_int_in, power_on_rst_n, sys_rst_pin_i};
        st_nxt.s2 = st_r.s1;
        st_nxt.div = st_r.div + 2'h1;
        if (st_r.div[0]) begin
            st_nxt.div4 = ~st_r.div4;
        end
        st_nxt.grant = 1'b0;
        unique case (st_r.cyc)
            CYC_IDLE: begin
                // Memory cycles leave the ask high and are not seen here
                if (!io_cycle_ask_n) begin
                    st_nxt.rd = !rd_wr_n;
                    st_nxt.wr = rd_wr_n;
                    st_nxt.bank = bank_select;
                    st_nxt.internal = chip_sel && (bank_select == BANK_INTERNAL);
                    st_nxt.ext = chip_sel && (bank_select != BANK_INTERNAL);
                    if (!chip_sel) begin
                        // Another controller owns the cycle: buffers only, never a grant
                        st_nxt.cyc = CYC_DONE;
                    end else if (bank_select == BANK_INTERNAL) begin
                        st_nxt.cyc = CYC_GRANT;
                    end else begin
                        st_nxt.wcnt = wait_sel;
                        st_nxt.cyc = CYC_WAIT;
                    end
                end
            end
            CYC_WAIT: begin
                if (st_r.wcnt != 4'h0) begin
                    st_nxt.wcnt = st_r.wcnt - 4'h1;
                end else if (cycle_type != TYPE_SYNC || tick4) begin
                    st_nxt.cyc = CYC_GRANT;
                end
            end
            CYC_GRANT: begin
                st_nxt.grant = 1'b1;
                st_nxt.cyc = CYC_DONE;
            end
            CYC_DONE: begin
                // Ask back high, or the grant given in this cycle, closes the cycle
                if (io_cycle_ask_n || st_r.grant) begin
                    st_nxt.cyc = CYC_IDLE;
                    st_nxt.rd = 1'b0;
                    st_nxt.wr = 1'b0;
                    st_nxt.ext = 1'b0;
                    st_nxt.internal = 1'b0;
                end
            end
        endcase
        // Edge interrupts latch; the set wins over a clear in the same cycle
        st_nxt.fall_prev = fall_s;
        st_nxt.rise_prev = rise_s;
        st_nxt.edge_st = st_r.edge_st & ~edge_clear;
        if (st_r.fall_prev && !fall_s) begin
            st_nxt.edge_st[0] = 1'b1;
        end
        if (!st_r.rise_prev && rise_s) begin
            st_nxt.edge_st[1] = 1'b1;
        end
        if (!por_s) begin
            st_nxt.edge_st[2] = 1'b1;
        end
        // Warm restart seen only once power-on reset has gone away
        st_nxt.rst_prev = rstpin_s;
        st_nxt.por_seen = por_s;
        st_nxt.warm = st_r.por_seen && por_s && st_r.rst_prev && !rstpin_s;
        if (baud_uf) begin
            st_nxt.baud = ~st_r.baud;
        end
        // Receiver at 16x oversample, LSB first
        if (kbd_uf) begin
            if (!st_r.rx_busy) begin
                if (!kin_s) begin
                    st_nxt.rx_busy = 1'b1;
                    st_nxt.rx_ph = 4'h0;
                    st_nxt.rx_bit = 4'h0;
                end
            end else begin
                st_nxt.rx_ph = st_r.rx_ph + 4'h1;
                if (st_r.rx_ph == HALF_BIT) begin
                    if (st_r.rx_bit == 4'h0 && kin_s) begin
                        st_nxt.rx_busy = 1'b0; // Short false start
                    end else if (st_r.rx_bit == 4'h8) begin
                        st_nxt.rx_data = {kin_s, st_r.rx_sh[7:1]};
                        st_nxt.rx_rdy = 1'b1;
                        st_nxt.rx_busy = 1'b0;
                    end else if (st_r.rx_bit != 4'h0) begin
                        st_nxt.rx_sh = {kin_s, st_r.rx_sh[7:1]};
                    end
                end
                if (st_r.rx_ph == OVERSAMPLE) begin
                    st_nxt.rx_bit = st_r.rx_bit + 4'h1;
                end
            end
        end
        // Transmitter: start, 8 data LSB first, two stop bits
        st_nxt.tx_done = st_r.tx_done;
        if (kbd_uf && st_r.tx_busy) begin
            st_nxt.tx_ph = st_r.tx_ph + 4'h1;
            if (st_r.tx_ph == OVERSAMPLE) begin
                st_nxt.tx_sh = {1'b1, st_r.tx_sh[10:1]};
                st_nxt.tx_bit = st_r.tx_bit + 4'h1;
                if (st_r.tx_bit == TX_FRAME_BITS - 4'h1) begin
                    st_nxt.tx_busy = 1'b0;
                    st_nxt.tx_done = 1'b1;
                end
            end
        end
        if (kbd_tx_load) begin
            st_nxt.tx_sh = {2'b11, kbd_tx_data, 1'b0};
            st_nxt.tx_busy = 1'b1;
            st_nxt.tx_ph = 4'h0;
            st_nxt.tx_bit = 4'h0;
            st_nxt.tx_done = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r <= '0;
            st_r.cyc <= CYC_IDLE;
            // Idle pin levels, so no false edge follows reset
            st_r.s1 <= 14'h3FFB;
            st_r.s2 <= 14'h3FFB;
            st_r.fall_prev <= 1'b1;
            st_r.rst_prev <= 1'b1;
            st_r.tx_sh <= 11'h7FF;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ==========================================
    // Outputs
    assign clk_div4_out = st_r.div4;
    assign clk_inv_out = ~clk;
    assign io_grant_n_o = 1'b0;
    assign io_grant_n_oe = st_r.grant;
    assign int_reg_sel = st_r.internal && st_r.grant;
    assign int_reg_index = word_index;
    // Transparent latch unless an external cycle is in progress
    assign data_latch_hold_n_o = 1'b0;
    assign data_latch_hold_n_oe = st_r.ext;
    assign rd_buffer_en_n = ~st_r.rd;
    assign wr_buffer_en_n = ~st_r.wr;
    assign external_select_n = ~st_r.ext;
    always_comb begin
        peripheral_select_n = 7'h7F;
        if (st_r.ext) begin
            peripheral_select_n[st_r.bank] = 1'b0;
        end
    end
    assign periph_rd_strobe_n = ~(st_r.ext && st_r.rd);
    assign periph_wr_strobe_n = ~(st_r.ext && st_r.wr);
    assign sys_rst_pin_o = 1'b0;
    assign sys_rst_pin_oe = ~por_s;
    assign warm_restart = st_r.warm;
    assign edge_status = st_r.edge_st;
    assign edge_request = st_r.edge_st & edge_mask;
    assign level_request = ~lvl_s & level_mask;
    assign fast_int_out_n = ~(fast_mask && (|fhi_s || !flo_s));
    assign control_pins_o = 6'h00;
    assign control_pins_oe = ~control_prog;
    assign control_pins_rd = ctl_s;
    assign baud_out = st_r.baud;
    assign kbd_rx_data = st_r.rx_data;
    assign kbd_rx_ready = st_r.rx_rdy;
    assign kbd_tx_done = st_r.tx_done;
    assign kbd_serial_out = st_r.tx_sh[0];

    // ==========================================
    // Checks
    a_grant_pulse: assert property (@(posedge clk) disable iff (sys_rst)
        io_grant_n_oe |=> !io_grant_n_oe) else $error("grant held too long");
    a_int_two_cyc: assert property (@(posedge clk) disable iff (sys_rst)
        (st_r.cyc == CYC_IDLE && !io_cycle_ask_n && chip_sel && bank_select == 3'h0)
        |=> ##1 io_grant_n_oe) else $error("internal access not two cycles");
    a_no_mem_cyc: assert property (@(posedge clk) disable iff (sys_rst)
        (st_r.cyc == CYC_IDLE && io_cycle_ask_n) |=> st_r.cyc == CYC_IDLE)
        else $error("memory cycle started io cycle");
    a_latch_ext: assert property (@(posedge clk) disable iff (sys_rst)
        data_latch_hold_n_oe == !external_select_n) else $error("latch mismatch");
    a_sel_onehot: assert property (@(posedge clk) disable iff (sys_rst)
        !external_select_n |-> $onehot(~peripheral_select_n))
        else $error("peripheral select not one-hot");
    a_buf_excl: assert property (@(posedge clk) disable iff (sys_rst)
        !(~rd_buffer_en_n && ~wr_buffer_en_n)) else $error("both buffers enabled");
    a_edge_sticky: assert property (@(posedge clk) disable iff (sys_rst)
        (edge_status[1] && !edge_clear[1]) |=> edge_status[1])
        else $error("edge status lost");
    a_baud_toggle: assert property (@(posedge clk) disable iff (sys_rst)
        baud_uf |=> baud_out != $past(baud_out)) else $error("baud not toggled");
    a_div4_period: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(clk_div4_out) |=> clk_div4_out ##1 !clk_div4_out)
        else $error("divide by four wrong");
    c_int_cycle: cover property (@(posedge clk) disable iff (sys_rst)
        int_reg_sel);
    c_ext_slow: cover property (@(posedge clk) disable iff (sys_rst)
        io_grant_n_oe && !external_select_n && cycle_type == TYPE_SLOW);
    c_kbd_rx: cover property (@(posedge clk) disable iff (sys_rst) $rose(kbd_rx_ready));
    c_warm: cover property (@(posedge clk) disable iff (sys_rst) warm_restart);
endmodule : iobc_ctrl

// ---- design/iobc_pkg.sv ----
package iobc_pkg;
    localparam int unsigned CLK_DIV = 4;
    localparam int unsigned INT_CYCLES = 2;
    localparam logic [3:0] WAIT_SLOW = 4'hA;
    localparam logic [3:0] WAIT_MED = 4'h6;
    localparam logic [3:0] WAIT_FAST = 4'h3;
    localparam logic [3:0] WAIT_SYNC = 4'h1;
    localparam logic [1:0] TYPE_SLOW = 2'h0;
    localparam logic [1:0] TYPE_MED = 2'h1;
    localparam logic [1:0] TYPE_FAST = 2'h2;
    localparam logic [1:0] TYPE_SYNC = 2'h3;
    localparam logic [2:0] BANK_INTERNAL = 3'h0;
    localparam logic [5:0] CTRL_RESET = 6'h3F;
    localparam logic [15:0] BAUD_RELOAD_RESET = 16'h0001;
    localparam logic [15:0] KBD_RELOAD_RESET = 16'h0001;
    localparam logic [3:0] OVERSAMPLE = 4'hF;
    localparam logic [3:0] HALF_BIT = 4'h7;
    localparam logic [3:0] TX_FRAME_BITS = 4'hB;
    typedef enum logic [1:0] {CYC_IDLE, CYC_WAIT, CYC_GRANT, CYC_DONE} iobc_cyc_t;
endpackage : iobc_pkg

// ---- design/iobc_reload_cnt.sv ----
`timescale 1ns/1ps
// ==========================================
// Reload down counter with tick enable
module iobc_reload_cnt import iobc_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Control
    input wire logic tick,
    input wire logic [15:0] reload,
    // Event
    output logic underflow
);
    typedef struct packed {
        logic [15:0] cnt;
        logic uf;
    } iobc_cnt_st_t;
    iobc_cnt_st_t st_r, st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.uf = 1'b0;
        if (tick) begin
            // A zero reload keeps reloading and never counts
            if (st_r.cnt <= 16'h0001) begin
                st_nxt.cnt = reload;
                st_nxt.uf = 1'b1;
            end else begin
                st_nxt.cnt = st_r.cnt - 16'h0001;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign underflow = st_r.uf;

    a_uf_pulse: assert property (@(posedge clk) disable iff (sys_rst)
        !tick |=> !underflow) else $error("underflow without a tick");
endmodule : iobc_reload_cnt

// ---- tb/iobc_sys_model.sv ----
`timescale 1ns/1ps
// ====
// System side: memory controller and processor making I/O cycles
module iobc_sys_model import iobc_pkg::*; (
    // Clock
    input wire logic clk,
    // Grant pin level
    input wire logic io_grant_n,
    // Request lines
    output logic io_cycle_ask_n,
    output logic [1:0] cycle_type,
    output logic rd_wr_n,
    output logic chip_sel,
    output logic [2:0] bank_select,
    output logic [4:0] word_index
);
    initial begin
        io_cycle_ask_n = 1'b1;
        cycle_type = 2'h0;
        rd_wr_n = 1'b0;
        chip_sel = 1'b0;
        bank_select = 3'h0;
        word_index = 5'h00;
    end

    // Request held whole until grant is seen low or limit edges pass; lat stays -1 if no grant
    task automatic cycle(input logic [1:0] typ, input logic wr, input logic cs,
            input logic [2:0] bank, input logic [4:0] idx, input int limit, output int lat);
        lat = -1;
        @(posedge clk);
        io_cycle_ask_n <= 1'b0;
        cycle_type <= typ;
        rd_wr_n <= wr;
        chip_sel <= cs;
        bank_select <= bank;
        word_index <= idx;
        for (int i = 1; i <= limit && lat < 0; i++) begin
            @(posedge clk);
            if (io_grant_n === 1'b0) lat = i;
        end
        io_cycle_ask_n <= 1'b1;
        // Lines no longer qualified: show something else than the last value
        word_index <= ~idx;
        bank_select <= ~bank;
        @(posedge clk);
        @(posedge clk);
    endtask : cycle

    // Memory references: lines move but the I/O request stays high
    task automatic memory_refs(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            io_cycle_ask_n <= 1'b1;
            chip_sel <= 1'b1;
            bank_select <= 3'(i);
            cycle_type <= 2'(i);
        end
    endtask : memory_refs
endmodule : iobc_sys_model

// ---- tb/io_bus_bridge_ctrl_test.sv ----
`timescale 1ns/1ps
module io_bus_bridge_ctrl_test import iobc_pkg::*; ();
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic power_on_rst_n = 1'b1;
    logic ext_rst_n = 1'b1;
    logic [7:0] level_int_in_n = 8'hFF;
    logic falling_int_in_n = 1'b1;
    logic rising_int_in = 1'b0;
    logic [1:0] fast_int_hi_in = 2'h0;
    logic fast_int_lo_in = 1'b1;
    logic [2:0] edge_clear = 3'h0;
    logic [2:0] edge_mask = 3'h0;
    logic [7:0] level_mask = 8'h00;
    logic fast_mask = 1'b1;
    logic [5:0] control_prog = 6'h3F;
    logic [5:0] ext_ctrl = 6'h3F;
    logic kbd_tx_load = 1'b0;
    logic [7:0] kbd_tx_data = 8'h00;
    logic kbd_serial_out, kbd_tx_done, kbd_rx_ready, int_reg_sel;
    logic [7:0] kbd_rx_data;
    logic io_cycle_ask_n, rd_wr_n, chip_sel, io_grant_n_o, io_grant_n_oe, io_grant_n;
    logic [1:0] cycle_type;
    logic [2:0] bank_select, edge_status, edge_request;
    logic [4:0] word_index, int_reg_index;
    logic clk_div4_out, clk_inv_out, data_latch_hold_n_o, data_latch_hold_n_oe;
    logic rd_buffer_en_n, wr_buffer_en_n, external_select_n;
    logic periph_rd_strobe_n, periph_wr_strobe_n, baud_out, fast_int_out_n;
    logic [7:1] peripheral_select_n;
    logic sys_rst_pin_i, sys_rst_pin_o, sys_rst_pin_oe, warm_restart;
    logic [7:0] level_request;
    logic [5:0] control_pins_i, control_pins_o, control_pins_oe, control_pins_rd;
    int miscompares = 0;
    int n_checks = 0;

    always #2.5 clk = ~clk;
    // Open-drain pins with pull-ups
    assign io_grant_n = io_grant_n_oe ? io_grant_n_o : 1'b1;
    assign sys_rst_pin_i = sys_rst_pin_oe ? sys_rst_pin_o : ext_rst_n;
    assign control_pins_i = ext_ctrl & ~(control_pins_oe & ~control_pins_o);

    iobc_sys_model sysm (.clk, .io_grant_n, .io_cycle_ask_n, .cycle_type, .rd_wr_n,
        .chip_sel, .bank_select, .word_index);

    iobc_ctrl uut (.clk, .sys_rst, .clk_div4_out, .clk_inv_out, .io_cycle_ask_n,
        .cycle_type, .rd_wr_n, .chip_sel, .bank_select, .word_index, .io_grant_n_o,
        .io_grant_n_oe, .int_reg_sel, .int_reg_index, .data_latch_hold_n_o,
        .data_latch_hold_n_oe, .rd_buffer_en_n, .wr_buffer_en_n, .external_select_n,
        .peripheral_select_n, .periph_rd_strobe_n, .periph_wr_strobe_n, .power_on_rst_n,
        .sys_rst_pin_i, .sys_rst_pin_o, .sys_rst_pin_oe, .warm_restart, .level_int_in_n,
        .falling_int_in_n, .rising_int_in, .fast_int_hi_in, .fast_int_lo_in, .edge_clear,
        .edge_mask, .level_mask, .fast_mask, .edge_status, .edge_request, .level_request,
        .fast_int_out_n, .control_prog, .control_pins_i, .control_pins_o, .control_pins_oe,
        .control_pins_rd, .baud_reload(16'h0003), .kbd_reload(16'h0001), .baud_out,
        .kbd_serial_in(kbd_serial_out), .kbd_rx_data, .kbd_rx_ready, .kbd_tx_load,
        .kbd_tx_data, .kbd_tx_done, .kbd_serial_out);

    // ====
    // Checking and closing
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic test_done;
        if (miscompares == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : test_done

    task automatic wait_settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wait_settle

    // ====
    // Scenarios
    task automatic cyc_test(input logic [1:0] typ, input logic wr, input logic cs,
            input logic [2:0] bank, input int lo, input int hi);
        int lat;
        logic ext;
        logic [6:0] sel_exp;
        ext = cs && (bank != BANK_INTERNAL);
        sel_exp = ext ? ~(7'h01 << (bank - 3'h1)) : 7'h7F;
        fork
            sysm.cycle(typ, wr, cs, bank, 5'h15, 20, lat);
            begin
                wait_settle(3);
                check("rd buffer", rd_buffer_en_n, wr);
                check("wr buffer", wr_buffer_en_n, !wr);
                check("ext select", external_select_n, !ext);
                check("periph select", peripheral_select_n, sel_exp);
                check("rd strobe", periph_rd_strobe_n, !(ext && !wr));
                check("wr strobe", periph_wr_strobe_n, !(ext && wr));
                check("latch", data_latch_hold_n_oe, ext);
                check("reg select", int_reg_sel, cs && !ext);
                if (cs && !ext) check("reg index", int_reg_index, 5'h15);
            end
        join
        check("grant latency", 16'(lat), 16'((lat >= lo && lat <= hi) ? lat : lo));
    endtask : cyc_test

    task automatic mem_refs_test;
        fork
            sysm.memory_refs(12);
            repeat (12) begin
                wait_settle(1);
                check("grant on memory ref", io_grant_n_oe, 1'b0);
                check("select on memory ref", external_select_n, 1'b1);
            end
        join
    endtask : mem_refs_test

    task automatic clock_test;
        logic [7:0] s;
        int gap [2];
        int last;
        for (int i = 0; i < 8; i++) begin
            wait_settle(1);
            s[i] = clk_div4_out;
            check("inverted clock low", clk_inv_out, 1'b0);
        end
        @(negedge clk);
        #1;
        check("inverted clock high", clk_inv_out, 1'b1);
        for (int i = 0; i < 4; i++) begin
            check("div4 half", s[i + 2], !s[i]);
            check("div4 period", s[i + 4], s[i]);
        end
        // Two toggle spans of the baud pin must match: a steady reload rate
        last = -1;
        gap = '{0, 0};
        for (int c = 0, k = 0, prev = baud_out; c < 200 && k < 3; c++) begin
            @(posedge clk);
            if (baud_out !== prev) begin
                if (k > 0) gap[k - 1] = c - last;
                last = c;
                k++;
                prev = baud_out;
            end
        end
        check("baud toggle span", 16'(gap[0]), 16'(3 * CLK_DIV));
        check("baud toggle span 2", 16'(gap[1]), 16'(3 * CLK_DIV));
    endtask : clock_test

    task automatic reset_pin_test;
        int pulses;
        @(posedge clk);
        power_on_rst_n <= 1'b0;
        wait_settle(4);
        check("reset pin driven", {sys_rst_pin_oe, sys_rst_pin_o}, 2'h2);
        check("no false edge", edge_status[1:0], 2'h0);
        @(posedge clk);
        power_on_rst_n <= 1'b1;
        wait_settle(4);
        check("reset pin released", sys_rst_pin_oe, 1'b0);
        check("por latched", edge_status[2], 1'b1);
        @(posedge clk);
        edge_clear <= 3'h4;
        @(posedge clk);
        edge_clear <= 3'h0;
        ext_rst_n <= 1'b0;
        pulses = 0;
        repeat (8) begin
            wait_settle(1);
            pulses += int'(warm_restart === 1'b1);
        end
        check("por cleared", edge_status[2], 1'b0);
        check("warm restart", 16'(pulses), 16'h0001);
        @(posedge clk);
        ext_rst_n <= 1'b1;
    endtask : reset_pin_test

    task automatic int_test;
        @(posedge clk);
        level_int_in_n <= 8'hA5;
        level_mask <= 8'h3C;
        wait_settle(4);
        check("level request", level_request, 8'h18);
        @(posedge clk);
        level_int_in_n <= 8'hFF;
        falling_int_in_n <= 1'b0;
        rising_int_in <= 1'b1;
        edge_mask <= 3'h1;
        fast_int_lo_in <= 1'b0;
        wait_settle(4);
        check("level removed", level_request, 8'h00);
        check("edge status", edge_status[1:0], 2'h3);
        check("edge request", edge_request, 3'h1);
        check("fast from low pin", fast_int_out_n, 1'b0);
        @(posedge clk);
        falling_int_in_n <= 1'b1;
        rising_int_in <= 1'b0;
        fast_int_lo_in <= 1'b1;
        fast_int_hi_in <= 2'h2;
        wait_settle(4);
        check("edge held", edge_status[1:0], 2'h3);
        check("fast from high pin", fast_int_out_n, 1'b0);
        @(posedge clk);
        edge_clear <= 3'h1;
        fast_int_hi_in <= 2'h0;
        @(posedge clk);
        edge_clear <= 3'h0;
        wait_settle(4);
        check("edge cleared", edge_status[1:0], 2'h2);
        check("fast idle", fast_int_out_n, 1'b1);
    endtask : int_test

    task automatic control_test;
        @(posedge clk);
        control_prog <= 6'h3A;
        ext_ctrl <= 6'h2F;
        wait_settle(4);
        check("ctrl enable", control_pins_oe, 6'h05);
        check("ctrl level", control_pins_o & control_pins_oe, 6'h00);
        check("ctrl read", control_pins_rd, 6'h2A);
    endtask : control_test

    // Output looped back to the receiver; one bit lasts 16 counter ticks
    task automatic kbd_test;
        check("rx ready idle", kbd_rx_ready, 1'b0);
        @(posedge clk);
        kbd_tx_data <= 8'h2D;
        kbd_tx_load <= 1'b1;
        @(posedge clk);
        kbd_tx_load <= 1'b0;
        wait_settle(8);
        check("start bit", kbd_serial_out, 1'b0);
        wait_settle(16);
        check("first data bit", kbd_serial_out, 1'b1);
        wait_settle(166);
        check("tx done", kbd_tx_done, 1'b1);
        check("stop level", kbd_serial_out, 1'b1);
        check("rx ready", kbd_rx_ready, 1'b1);
        check("rx data", kbd_rx_data, 8'h2D);
    endtask : kbd_test

    // ====
    // Main sequence and watchdog
    initial begin
        logic [3:0] w;
        int lo;
        int hi;
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        reset_pin_test();
        clock_test();
        mem_refs_test();
        for (int t = 0; t < 4; t++) begin
            for (int b = 0; b < 8; b++) begin
                w = (t == 0) ? WAIT_SLOW : (t == 1) ? WAIT_MED : (t == 2) ? WAIT_FAST : WAIT_SYNC;
                lo = (b == 0) ? int'(INT_CYCLES) + 1 : int'(w) + 4;
                hi = (b == 0 || t != 3) ? lo : lo + 3;
                cyc_test(2'(t), 1'(b ^ t), 1'b1, 3'(b), lo, hi);
            end
        end
        cyc_test(TYPE_FAST, 1'b0, 1'b0, 3'h2, -1, -1);
        cyc_test(TYPE_SLOW, 1'b1, 1'b0, 3'h0, -1, -1);
        int_test();
        control_test();
        kbd_test();
        test_done();
    end

    // Run needs about 700 cycles; allow ample margin
    initial begin
        #60000;
        miscompares++;
        test_done();
    end
endmodule : io_bus_bridge_ctrl_test
